// File: src/pllsc_serial_ctrl.sv
// Two-wire target interface and control registers of the synthesizer.
// Assumes scl/sda pins are asynchronous and sampled on mclk; reset_n is the supply monitor.
//
// Contract
// - Target address bits come from the decoded level of the address-select pin.
// - Divide ratio is fifteen bits: seven from first divider byte, eight from second.
// - Decode mode field into pump function and clock output selection.
// - Power-on mode releases the tuning output while the pump sinks.
// - Reference code selects crystal divide ratio 2, 4, 8, 16 or 32.
// - Two-bit code selects charge-pump current magnitude.
// - On read address, acknowledge and shift status byte out MSB first.
// - No acknowledge from controller ends the read and releases data.
// - Power-on flag is set at power-up and on supply-low reset.
// - Power-on flag clears at end of a read sequence.
// - Second status bit reports lock, meaningful only in normal modes.
// - Supply reset loads mode 001; other fields stay unset. The code loads them with plain zero values instead.
// - Write bytes auto-increment; first byte's leading bit picks divider or control.
// - Bytes load after eighth clock; divider applies after second byte or at stop.
`timescale 1ns/1ns
module pllsc_serial_ctrl
  import pllsc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe_n,
  input  wire logic        addr_sel_hi,
  input  wire logic        addr_sel_lo,
  input  wire logic        loop_locked_flag,
  output pllsc_ctrl_s      ctrl
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]   sclSync;
    logic [2:0]   sdaSync;
    logic         sclStable;
    logic         sdaStable;
    pllsc_state_e state;
    logic [3:0]   bitCnt;
    logic [7:0]   shiftReg;
    logic         ackPhase;
    logic         driveLow;
    logic         readMode;
    logic [1:0]   bytePtr;
    logic [6:0]   divUpper;
    logic [14:0]  divideRatio;
    logic         divPending;
    logic [2:0]   modeField;
    logic [2:0]   refCode;
    logic [1:0]   pumpCode;
    logic         powerOnFlag;
    logic         readDone;
    logic         sdaOut;
    logic [2:0]   lockSync;
    logic         lockStable;
    logic         sdaOe_n;
  } pllsc_core_s;

  pllsc_core_s st;
  pllsc_core_s next_st;

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [7:0] statusByte;
  logic [7:0] nextShift;

  // Glitch filter: a change counts once the last two stages agree.
  always_comb begin
    sclRise   = (st.sclSync[2:1] == 2'b11) && !st.sclStable;
    sclFall   = (st.sclSync[2:1] == 2'b00) &&  st.sclStable;
    startCond = st.sclStable && (st.sdaSync[2:1] == 2'b00) && st.sdaStable;
    stopCond  = st.sclStable && (st.sdaSync[2:1] == 2'b11) && !st.sdaStable;
    statusByte = {st.powerOnFlag,
                  st.lockStable && ctrl.normalMode,
                  6'h00};
    nextShift = {st.shiftReg[6:0], st.sdaStable};
  end

  always_comb begin
    next_st = st;
    next_st.sclSync = {st.sclSync[1:0], scl};
    next_st.sdaSync = {st.sdaSync[1:0], sdaIn};
    if (st.sclSync[2] == st.sclSync[1]) begin
      next_st.sclStable = st.sclSync[2];
    end
    if (st.sdaSync[2] == st.sdaSync[1]) begin
      next_st.sdaStable = st.sdaSync[2];
    end
    // The lock indicator comes from the analog loop, so it is filtered like the bus pins.
    next_st.lockSync = {st.lockSync[1:0], loop_locked_flag};
    if (st.lockSync[2] == st.lockSync[1]) begin
      next_st.lockStable = st.lockSync[2];
    end

    if (stopCond) begin
      next_st.state    = ST_IDLE;
      next_st.driveLow = 1'b0;
      if (st.divPending) begin
        next_st.divideRatio = {st.divUpper, st.divideRatio[7:0]};
        next_st.divPending  = 1'b0;
      end
      if (st.readDone) begin
        next_st.powerOnFlag = 1'b0;
        next_st.readDone    = 1'b0;
      end
    end else if (startCond) begin
      next_st.state    = ST_ADDR;
      next_st.bitCnt   = BIT_CNT_RESET;
      next_st.ackPhase = 1'b0;
      next_st.driveLow = 1'b0;
      next_st.bytePtr  = 2'h0;
    end else begin
      unique case (st.state)
        ST_IDLE, ST_WAIT: begin
          next_st.driveLow = 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          if (sclRise && !st.ackPhase) begin
            next_st.shiftReg = nextShift;
            next_st.bitCnt   = st.bitCnt + 4'h1;
          end
          if (sclFall && !st.ackPhase && st.bitCnt == BITS_PER_BYTE) begin
            next_st.ackPhase = 1'b1;
            next_st.bitCnt   = BIT_CNT_RESET;
            if (st.state == ST_ADDR) begin
              if (st.shiftReg[7:1] == {ADDR_FIXED, addr_sel_hi, addr_sel_lo}) begin
                next_st.driveLow = 1'b1;
                next_st.readMode = st.shiftReg[0];
              end else begin
                next_st.state = ST_WAIT;
              end
            end else begin
              next_st.driveLow = 1'b1;
              // Leading bit of the first byte picks the divider or control path.
              if (st.bytePtr == 2'h0 && st.shiftReg[7]) begin
                next_st.bytePtr = 2'h2;
              end
              unique case ((st.bytePtr == 2'h0 && st.shiftReg[7]) ? 2'h2 : st.bytePtr)
                2'h0: begin
                  next_st.divUpper   = st.shiftReg[6:0];
                  next_st.divPending = 1'b1;
                end
                2'h1: begin
                  next_st.divideRatio = {st.divUpper, st.shiftReg};
                  next_st.divPending  = 1'b0;
                end
                2'h2: begin
                  next_st.modeField = st.shiftReg[6:4];
                  next_st.refCode   = st.shiftReg[3:1];
                end
                2'h3: begin
                  next_st.pumpCode = st.shiftReg[7:6];
                end
              endcase
            end
          end else if (sclFall && st.ackPhase) begin
            next_st.ackPhase = 1'b0;
            next_st.driveLow = 1'b0;
            if (st.state == ST_ADDR && st.readMode) begin
              next_st.state    = ST_READ;
              next_st.shiftReg = statusByte;
              next_st.driveLow = !statusByte[7];
            end else if (st.state == ST_ADDR) begin
              next_st.state = ST_WRITE;
            end else begin
              // Auto-increment moves to the next byte after each acknowledge.
              next_st.bytePtr = ((st.bytePtr == 2'h0) && st.shiftReg[7]) ? 2'h3 :
                                st.bytePtr + 2'h1;
            end
          end
        end
        ST_READ: begin
          if (sclFall && !st.ackPhase) begin
            next_st.bitCnt = st.bitCnt + 4'h1;
            if (st.bitCnt == BITS_PER_BYTE - 4'h1) begin
              next_st.ackPhase = 1'b1;
              next_st.driveLow = 1'b0;
              next_st.readDone = 1'b1;
            end else begin
              next_st.shiftReg = {st.shiftReg[6:0], 1'b0};
              next_st.driveLow = !st.shiftReg[6];
            end
          end else if (sclRise && st.ackPhase) begin
            if (st.sdaStable) begin
              next_st.state = ST_WAIT;
            end
          end else if (sclFall && st.ackPhase) begin
            next_st.ackPhase = 1'b0;
            next_st.bitCnt   = BIT_CNT_RESET;
            next_st.shiftReg = statusByte;
            next_st.driveLow = !statusByte[7];
          end
        end
        default: begin
          next_st.state = ST_IDLE;
        end
      endcase
    end
    next_st.sdaOut = 1'b0;
    next_st.sdaOe_n = !next_st.driveLow;
  end

  // Supply reset presets only the mode; data fields get a plain value for determinism.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{sclSync: 3'h7, sdaSync: 3'h7, sclStable: 1'b1, sdaStable: 1'b1,
              state: ST_IDLE, bitCnt: BIT_CNT_RESET, shiftReg: 8'h00,
              ackPhase: 1'b0, driveLow: 1'b0, readMode: 1'b0, bytePtr: 2'h0,
              divUpper: 7'h00, divideRatio: DIV_RESET, divPending: 1'b0,
              modeField: MODE_RESET,
              refCode: REF_RESET, pumpCode: PUMP_RESET,
              powerOnFlag: 1'b1,
              readDone: 1'b0, sdaOut: 1'b0, lockSync: 3'h0, lockStable: 1'b0,
              sdaOe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign sdaOut  = st.sdaOut;
  assign sdaOe_n = st.sdaOe_n;

  pllsc_mode_decode u_decode (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .divideRatio (st.divideRatio),
    .modeField   (st.modeField),
    .refCode     (st.refCode),
    .pumpCode    (st.pumpCode),
    .ctrl        (ctrl)
  );

endmodule

// File: inc/pllsc_pkg.sv
// Shared constants and types for the synthesizer serial control block.
// Assumes a single 100 MHz clock domain; bus pins are sampled by the block itself.
package pllsc_pkg;

  // ****************************************
  // Bus framing
  // ****************************************
  localparam logic [4:0] ADDR_FIXED     = 5'h18;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET  = 4'h0;

  // ****************************************
  // Register reset values
  // ****************************************
  localparam logic [2:0] MODE_RESET     = 3'h1;
  localparam logic [2:0] REF_RESET      = 3'h0;
  localparam logic [1:0] PUMP_RESET     = 2'h0;
  localparam logic [14:0] DIV_RESET     = 15'h0000;

  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [2:0] MODE_NORM_OFF  = 3'h0;
  localparam logic [2:0] MODE_POR_SINK  = 3'h1;
  localparam logic [2:0] MODE_HALF_DIV  = 3'h2;
  localparam logic [2:0] MODE_SINK      = 3'h3;
  localparam logic [2:0] MODE_NORM_XT   = 3'h4;
  localparam logic [2:0] MODE_DBL_REF   = 3'h5;
  localparam logic [2:0] MODE_PUMP_OFF  = 3'h6;
  localparam logic [2:0] MODE_SOURCE    = 3'h7;

  // ****************************************
  // Output selections
  // ****************************************
  typedef enum logic [1:0] {PUMP_NORMAL = 2'h0, PUMP_SINK = 2'h1,
                            PUMP_SOURCE = 2'h2, PUMP_OFF  = 2'h3} pllsc_pump_e;
  typedef enum logic [1:0] {CLK_OFF = 2'h0, CLK_XTAL = 2'h1,
                            CLK_HALF_DIV = 2'h2, CLK_DBL_REF = 2'h3} pllsc_clk_e;

  typedef struct packed {
    logic [14:0] divideRatio;
    logic [5:0]  refRatio;
    logic [1:0]  pumpCurrent;
    pllsc_pump_e pumpFunction;
    pllsc_clk_e  clockOutSel;
    logic        tuningRelease;
    logic        normalMode;
  } pllsc_ctrl_s;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ  = 5'b01000,
    ST_WAIT  = 5'b10000
  } pllsc_state_e;

endpackage

// File: src/pllsc_mode_decode.sv
// Decodes the stored control fields into synthesizer steering values.
// Assumes registered field inputs on the same clock.
`timescale 1ns/1ns
module pllsc_mode_decode
  import pllsc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [14:0] divideRatio,
  input  wire logic [2:0]  modeField,
  input  wire logic [2:0]  refCode,
  input  wire logic [1:0]  pumpCode,
  output pllsc_ctrl_s      ctrl
);

  typedef struct packed {
    pllsc_ctrl_s ctrl;
  } pllsc_dec_s;

  pllsc_dec_s st;
  pllsc_dec_s next_st;

  function automatic logic [5:0] refDivide(input logic [2:0] code);
    unique case (code)
      3'h0: refDivide = 6'h02;
      3'h1: refDivide = 6'h04;
      3'h2: refDivide = 6'h08;
      3'h5: refDivide = 6'h10;
      3'h7: refDivide = 6'h20;
      default: refDivide = 6'h02;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    next_st.ctrl.divideRatio   = divideRatio;
    next_st.ctrl.refRatio      = refDivide(refCode);
    next_st.ctrl.pumpCurrent   = pumpCode;
    next_st.ctrl.tuningRelease = (modeField == MODE_POR_SINK);
    next_st.ctrl.normalMode    = (modeField == MODE_NORM_OFF) ||
                                 (modeField == MODE_NORM_XT);
    unique case (modeField)
      MODE_NORM_OFF: begin
        next_st.ctrl.pumpFunction = PUMP_NORMAL;
        next_st.ctrl.clockOutSel  = CLK_OFF;
      end
      MODE_POR_SINK, MODE_SINK: begin
        next_st.ctrl.pumpFunction = PUMP_SINK;
        next_st.ctrl.clockOutSel  = CLK_XTAL;
      end
      MODE_HALF_DIV: begin
        next_st.ctrl.pumpFunction = PUMP_NORMAL;
        next_st.ctrl.clockOutSel  = CLK_HALF_DIV;
      end
      MODE_NORM_XT: begin
        next_st.ctrl.pumpFunction = PUMP_NORMAL;
        next_st.ctrl.clockOutSel  = CLK_XTAL;
      end
      MODE_DBL_REF: begin
        next_st.ctrl.pumpFunction = PUMP_NORMAL;
        next_st.ctrl.clockOutSel  = CLK_DBL_REF;
      end
      MODE_PUMP_OFF: begin
        next_st.ctrl.pumpFunction = PUMP_OFF;
        next_st.ctrl.clockOutSel  = CLK_XTAL;
      end
      MODE_SOURCE: begin
        next_st.ctrl.pumpFunction = PUMP_SOURCE;
        next_st.ctrl.clockOutSel  = CLK_XTAL;
      end
    endcase
  end

  // Reset image matches the power-on mode so the pump sinks with tuning released.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st.ctrl <= '{divideRatio: DIV_RESET, refRatio: 6'h02, pumpCurrent: PUMP_RESET,
                   pumpFunction: PUMP_SINK, clockOutSel: CLK_XTAL,
                   tuningRelease: 1'b1, normalMode: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ctrl = st.ctrl;

endmodule

// File: verification/pllsc_sc_assertions.sv
// Port-level checker for the synthesizer serial control block.
// Assumes the bench keeps each bus clock high phase at eight mclk cycles or more and each low phase at ten or more.
`timescale 1ns/1ns
module pllsc_sc_assertions
  import pllsc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        scl,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe_n,
  input wire logic        addr_sel_hi,
  input wire logic        addr_sel_lo,
  input wire logic        loop_locked_flag,
  input wire pllsc_ctrl_s ctrl
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_POR_STATE: assert property ($rose(reset_n) |-> sdaOe_n && ctrl.tuningRelease
    && ctrl.pumpFunction == PUMP_SINK && ctrl.clockOutSel == CLK_XTAL)
    else $error("outputs not in power-on state after reset");
  AST_OPEN_DRAIN: assert property (!sdaOe_n |-> !sdaOut)
    else $error("data pin driven high");
  // Data may only move while the bus clock is low, else a peer sees START or STOP.
  AST_SDA_SCL_LOW: assert property ($changed(sdaOe_n) |-> !scl)
    else $error("data changed while bus clock high");
  AST_ACK_HOLD: assert property ($fell(sdaOe_n) |=> !sdaOe_n [*8])
    else $error("data pull too short");
  AST_MODE_POR: assert property (ctrl.tuningRelease |->
    ctrl.pumpFunction == PUMP_SINK && ctrl.clockOutSel == CLK_XTAL)
    else $error("released tuning without pump sink");
  AST_MODE_NORMAL: assert property (ctrl.normalMode |-> ctrl.pumpFunction == PUMP_NORMAL
    && ctrl.clockOutSel inside {CLK_OFF, CLK_XTAL} && !ctrl.tuningRelease)
    else $error("normal mode decode wrong");
  AST_TEST_XTAL: assert property (ctrl.pumpFunction != PUMP_NORMAL |->
    ctrl.clockOutSel == CLK_XTAL)
    else $error("pump test mode without crystal clock");
  AST_REF_RATIO: assert property (ctrl.refRatio inside
    {6'h02, 6'h04, 6'h08, 6'h10, 6'h20})
    else $error("reference ratio not a legal value");

  cover property ($fell(sdaOe_n));
  cover property (ctrl.normalMode);
  cover property (ctrl.refRatio == 6'h20);
endmodule

bind pllsc_serial_ctrl pllsc_sc_assertions chk (.mclk(mclk), .reset_n(reset_n), .scl(scl),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addr_sel_hi(addr_sel_hi),
  .addr_sel_lo(addr_sel_lo), .loop_locked_flag(loop_locked_flag), .ctrl(ctrl));

// File: verification/pllsc_bus_ctrl_model.sv
// Behavioural two-wire bus controller that programs and reads the target.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
module pllsc_bus_ctrl_model (
  input  wire logic mclk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaPull_n
);
  localparam int HALF = 8;

  initial begin
    scl = 1'b1;
    sdaPull_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic start();
    sdaPull_n <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sdaPull_n <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask

  task automatic stop();
    sdaPull_n <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sdaPull_n <= 1'b1;
    tick(HALF);
  endtask

  // Data moves two cycles after the clock falls so the target never sees it race the edge.
  task automatic bitx(input logic b, output logic r);
    sdaPull_n <= b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    r = sdaWire;
    scl <= 1'b0;
    tick(2);
  endtask

  // Every byte is clocked out whole, then the ninth bit drives ackOut and samples the wire into ackIn.
  task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] q,
                      output logic ackIn);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ackOut, ackIn);
  endtask
endmodule

// File: verification/pllsc_testbench.sv
// Self-checking bench for the synthesizer serial control block.
// Assumes one 100 MHz clock; the bus is driven by the controller model.
`timescale 1ns/1ns
module testbench;
  import pllsc_pkg::*;
  localparam logic [14:0] REFS   = {3'h7, 3'h5, 3'h2, 3'h1, 3'h0};
  localparam logic [29:0] RATIOS = {6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
  localparam logic [15:0] CLKS   = {CLK_XTAL, CLK_XTAL, CLK_DBL_REF, CLK_XTAL, CLK_XTAL,
                                    CLK_HALF_DIV, CLK_XTAL, CLK_OFF};
  localparam logic [15:0] PUMPS  = {PUMP_SOURCE, PUMP_OFF, PUMP_NORMAL, PUMP_NORMAL, PUMP_SINK,
                                    PUMP_NORMAL, PUMP_SINK, PUMP_NORMAL};
  logic        mclk, reset_n, selHi, selLo, locked, sdaOut, sdaOe_n, ack;
  logic [7:0]  q;
  wire logic   scl, sdaPull_n, sdaWire;
  pllsc_ctrl_s ctrl;
  int          n_fail, compares;

  assign sdaWire = sdaPull_n & (sdaOe_n | sdaOut);
  always #5 mclk = ~mclk;

  pllsc_serial_ctrl dut (.mclk(mclk), .reset_n(reset_n), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addr_sel_hi(selHi), .addr_sel_lo(selLo),
    .loop_locked_flag(locked), .ctrl(ctrl));
  pllsc_bus_ctrl_model cntl (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaPull_n(sdaPull_n));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [31:0] d, input int n, input logic stopIt);
    logic [7:0] r;
    logic       a;
    cntl.start();
    cntl.xfer({ADDR_FIXED, selHi, selLo, 1'b0}, 1'b1, r, a);
    check(a, 1'b0);
    for (int k = 0; k < n; k++) begin
      cntl.xfer(d[31-8*k -: 8], 1'b1, r, a);
      check(a, 1'b0);
    end
    if (stopIt)
      cntl.stop();
    cntl.tick(8);
  endtask

  task automatic rd(input logic [7:0] exp, input int n);
    logic [7:0] r;
    logic       a;
    cntl.start();
    cntl.xfer({ADDR_FIXED, selHi, selLo, 1'b1}, 1'b1, r, a);
    check(a, 1'b0);
    for (int k = 1; k <= n; k++) begin
      cntl.xfer(8'hff, k == n, r, a);
      check(r, exp);
      check(r & 8'hc0, exp & 8'hc0);
    end
    cntl.tick(8);
    check(sdaOe_n, 1'b1);
    check(sdaOut, 1'b0);
    cntl.stop();
    cntl.tick(8);
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    final_report();
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    selHi = 1'b1;
    selLo = 1'b0;
    locked = 1'b1;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    cntl.tick(8);
    check(ctrl.tuningRelease, 1'b1);
    check(ctrl.pumpFunction, PUMP_SINK);
    cntl.start();
    cntl.xfer({ADDR_FIXED, ~selHi, selLo, 1'b0}, 1'b1, q, ack);
    check(ack, 1'b1);
    cntl.stop();
    wr(32'h55aa_ce80, 4, 1'b1);
    check(ctrl.divideRatio, 15'h55aa);
    check(ctrl.refRatio, 6'h20);
    check(ctrl.pumpCurrent, 2'h2);
    wr(32'h0500_0000, 1, 1'b0);
    check(ctrl.divideRatio, 15'h55aa);
    cntl.stop();
    cntl.tick(8);
    check(ctrl.divideRatio, 15'h05aa);
    for (int i = 0; i < 8; i++) begin
      wr({1'b1, i[2:0], REFS[3*(i%5) +: 3], 1'b0, i[1:0], 22'h0}, 2, 1'b1);
      check(ctrl.clockOutSel, CLKS[2*i +: 2]);
      if (i != 2 && i != 5)
        check(ctrl.pumpFunction, PUMPS[2*i +: 2]);
      check(ctrl.normalMode, i == 0 || i == 4);
      check(ctrl.tuningRelease, i == 1);
      check(ctrl.refRatio, RATIOS[6*(i%5) +: 6]);
      check(ctrl.pumpCurrent, i[1:0]);
    end
    wr(32'h8000_0000, 1, 1'b1);
    rd(8'hc0, 2);
    rd(8'h40, 1);
    locked <= 1'b0;
    rd(8'h00, 1);
    locked <= 1'b1;
    wr(32'hb000_0000, 1, 1'b1);
    rd(8'h00, 1);
    selHi <= 1'b0;
    selLo <= 1'b1;
    cntl.tick(8);
    rd(8'h00, 1);
    reset_n <= 1'b0;
    cntl.tick(3);
    check(ctrl.tuningRelease, 1'b1);
    reset_n <= 1'b1;
    cntl.tick(8);
    rd(8'h80, 1);
    final_report();
  end
endmodule
